// ===== logic/standby_mode_controller.sv
// Standby mode controller: sleep, stop and watch modes, pin float,
// software reset.
// Assumes the CPU register port and interrupt requests are synchronous
// to clk_sys; oscillator ready strobes come from timebase and prescaler.
//
// Function
// - Sleep stops CPU clock, peripherals run
// - Sub sleep stops timebase timer
// - Sleep write ignored while interrupt pending
// - Reset or level wake ends sleep
// - Interrupt wake resumes normal handling
// - Reset waits oscillator, pins reset
// - Main stop keeps subclock, watch prescaler, externals
// - Sub stop keeps only external interrupts
// - Stop write enters stop, pin float
// - Stop write ignored while pending
// - Only reset or external interrupt ends stop
// - Stop wake waits oscillator stabilization
// - Watch write accepted only in subclock
// - Watch keeps prescaler, externals, pin float
// - Watch write ignored while pending
// - Reset, watch or external ends watch
// - Request bits 7,6,3 read zero
// - Pin float bit 5, reset zero
// - Bit 4 zero gives software reset
// - Sub software reset waits main oscillator
// - Bits 2..0 unused, writes ignored
// - Priority stop, then watch, then sleep
// - Wait ends on timebase or prescaler
`timescale 1ns/1ps

module standby_mode_controller (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // Clock mode and wake sources
    input wire logic systemClockSourceSelect,
    input wire logic irqPending,
    input wire smc_pkg::smc_wake_t wake,
    input wire logic timebaseReady,
    input wire logic watchPrescalerReady,
    input wire logic pullUpSelect,
    // Gating and status
    output smc_pkg::smc_gate_t gate,
    output logic pinHold,
    output logic pinFloat,
    output logic pinPullHigh,
    output logic internalReset,
    output logic wakeResume,
    output smc_pkg::smc_state_t modeState
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    smc_pkg::smc_state_t state_q;
    smc_pkg::smc_state_t state_d;
    logic pinFloat_q;
    logic fromSub_q;
    logic wakeIrq_q;

    wire logic wrCtl = regWrite && (regAddr == smc_pkg::ADDR_STANDBY_CONTROL);
    wire logic inRun = (state_q == smc_pkg::ST_MAIN_RUN) ||
        (state_q == smc_pkg::ST_SUB_RUN);
    wire logic subMode = (state_q == smc_pkg::ST_SUB_RUN);
    // A pending request blocks entry; the request is simply dropped.
    wire logic entryOk = wrCtl && inRun && !irqPending;
    wire logic reqStop = entryOk && regWdata[smc_pkg::BIT_STOP_REQ];
    wire logic reqWatch = entryOk && regWdata[smc_pkg::BIT_WATCH_REQ]
        && !systemClockSourceSelect && subMode;
    wire logic reqSleep = entryOk && regWdata[smc_pkg::BIT_SLEEP_REQ];
    wire logic softTrig = wrCtl && inRun &&
        !regWdata[smc_pkg::BIT_SOFT_RESET];

    // Wake qualification: level 2'b11 is the lowest and never wakes.
    wire logic wakePeriph = wake.periphReq &&
        (wake.periphLevel != smc_pkg::LEVEL_WAKE_LIMIT);
    wire logic wakeExt = wake.extReq &&
        (wake.extLevel != smc_pkg::LEVEL_WAKE_LIMIT);
    wire logic wakeWatch = wake.watchReq &&
        (wake.watchLevel != smc_pkg::LEVEL_WAKE_LIMIT);
    wire logic wakeSleep = wakePeriph || wakeExt || wakeWatch;
    wire logic wakeStop = wakeExt;
    wire logic wakeWatchMode = wakeWatch || wakeExt;
    wire logic oscReady = fromSub_q ? watchPrescalerReady
        : timebaseReady;

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine

    wire logic softHold;
    logic softActive;

    always_comb begin
        state_d = state_q;
        case (state_q)
            smc_pkg::ST_MAIN_RUN, smc_pkg::ST_SUB_RUN: begin
                // The run state follows the clock source select level.
                // Oscillator settling on a sub-to-main switch is left to
                // the clock-mode logic outside this block.
                if (subMode == systemClockSourceSelect) begin
                    state_d = subMode ? smc_pkg::ST_MAIN_RUN
                        : smc_pkg::ST_SUB_RUN;
                end
                if (reqStop) begin
                    state_d = smc_pkg::ST_STOP;
                end else if (reqWatch) begin
                    state_d = smc_pkg::ST_WATCH;
                end else if (reqSleep) begin
                    state_d = smc_pkg::ST_SLEEP;
                end
                if (softTrig && subMode) begin
                    state_d = smc_pkg::ST_RESET_WAIT;
                end
            end
            smc_pkg::ST_SLEEP: begin
                if (wakeSleep) begin
                    state_d = fromSub_q ? smc_pkg::ST_SUB_RUN
                        : smc_pkg::ST_MAIN_RUN;
                end
            end
            smc_pkg::ST_STOP: begin
                if (wakeStop) begin
                    state_d = smc_pkg::ST_OSC_WAIT;
                end
            end
            smc_pkg::ST_WATCH: begin
                if (wakeWatchMode) begin
                    state_d = smc_pkg::ST_SUB_RUN;
                end
            end
            smc_pkg::ST_OSC_WAIT: begin
                if (oscReady) begin
                    state_d = fromSub_q ? smc_pkg::ST_SUB_RUN
                        : smc_pkg::ST_MAIN_RUN;
                end
            end
            smc_pkg::ST_RESET_WAIT: begin
                if (timebaseReady) begin
                    state_d = smc_pkg::ST_MAIN_RUN;
                end
            end
            default: begin
                state_d = smc_pkg::ST_MAIN_RUN;
            end
        endcase
    end

    // Reset from sub sleep, stop or watch would need the main oscillator,
    // so asynchronous reset loads the wait state directly, instead of the
    // main-run default; the timebase strobe then releases the core.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= smc_pkg::ST_RESET_WAIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Clock mode remembered at entry for the wake path and wait source.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fromSub_q <= 1'b0;
        end else if (inRun) begin
            fromSub_q <= subMode;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pinFloat_q <= smc_pkg::PIN_FLOAT_RESET;
        end else if (wrCtl) begin
            pinFloat_q <= regWdata[smc_pkg::BIT_PIN_FLOAT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software reset

    assign softHold = (state_q == smc_pkg::ST_RESET_WAIT);

    smc_soft_reset u_soft_reset (
        .clk_sys(clk_sys),
        .reset(reset),
        .trigger(softTrig),
        .holdOn(softHold),
        .softResetActive(softActive)
    );

    ////////////////////////////////////////////////////////////////////////
    // Gate decode

    wire logic isSleep = (state_q == smc_pkg::ST_SLEEP);
    wire logic isStop = (state_q == smc_pkg::ST_STOP);
    wire logic isWatch = (state_q == smc_pkg::ST_WATCH);
    wire logic lowPin = isStop || isWatch;
    smc_pkg::smc_gate_t gate_d;

    always_comb begin
        gate_d.cpuClkEn = inRun;
        gate_d.watchdogClkEn = inRun;
        gate_d.periphClkEn = inRun || isSleep;
        gate_d.mainOscEn = !fromSub_q && !isStop && !isWatch;
        gate_d.timebaseClkEn = gate_d.mainOscEn;
        gate_d.subOscEn = !(isStop && fromSub_q);
        gate_d.watchPrescalerEn = gate_d.subOscEn;
        gate_d.watchIrqAllow = !isStop;
        gate_d.extIrqEn = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and read data

    wire logic [7:0] ctlRead = {1'b0, 1'b0, pinFloat_q, 1'b1, 1'b0,
        smc_pkg::UNUSED_READ};
    wire logic [7:0] statRead = {5'h00, state_q};
    wire logic [7:0] rdSel = (regAddr == smc_pkg::ADDR_STANDBY_CONTROL)
        ? ctlRead
        : (regAddr == smc_pkg::ADDR_STATUS) ? statRead : 8'h00;
    wire logic leaving = !inRun && (state_d == smc_pkg::ST_MAIN_RUN ||
        state_d == smc_pkg::ST_SUB_RUN) &&
        (state_q != smc_pkg::ST_RESET_WAIT);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            regRdata <= 8'h00;
            gate <= '0;
            pinHold <= 1'b0;
            pinFloat <= 1'b0;
            pinPullHigh <= 1'b0;
            internalReset <= 1'b1;
            wakeResume <= 1'b0;
            modeState <= smc_pkg::ST_RESET_WAIT;
        end else begin
            regRdata <= regRead ? rdSel : 8'h00;
            gate <= gate_d;
            pinHold <= lowPin && !pinFloat_q;
            pinFloat <= lowPin && pinFloat_q && !pullUpSelect;
            pinPullHigh <= lowPin && pinFloat_q && pullUpSelect;
            internalReset <= softActive || softHold;
            wakeResume <= leaving;
            modeState <= state_q;
        end
    end

endmodule : standby_mode_controller

// ===== logic/smc_pkg.sv
// Package of the standby mode controller: register layout, states and
// carrier structs.
// Assumes a single 20 MHz system clock and an 8-bit register port.
package smc_pkg;

    // Standby control register location and fields.
    localparam logic [3:0] ADDR_STANDBY_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam int BIT_STOP_REQ = 7;
    localparam int BIT_SLEEP_REQ = 6;
    localparam int BIT_PIN_FLOAT = 5;
    localparam int BIT_SOFT_RESET = 4;
    localparam int BIT_WATCH_REQ = 3;
    localparam logic PIN_FLOAT_RESET = 1'b0;
    localparam logic [2:0] UNUSED_READ = 3'h0;

    // Interrupt levels: a request wakes when its level is above 2'b11
    // in the priority sense, which means numerically below it.
    localparam logic [1:0] LEVEL_WAKE_LIMIT = 2'h3;

    // Clock and timing.
    localparam int CLK_MHZ = 20;
    localparam int INSTR_CYCLE_NS = 200;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int SOFT_RESET_CYCLES = 4 * INSTR_CYCLE_NS / CLK_PERIOD_NS;
    localparam int SRST_CNT_W = 6;

    typedef enum logic [2:0] {
        ST_MAIN_RUN = 3'b000,
        ST_SUB_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_STOP = 3'b011,
        ST_WATCH = 3'b100,
        ST_OSC_WAIT = 3'b101,
        ST_RESET_WAIT = 3'b110
    } smc_state_t;

    // Wake sources presented by the interrupt logic.
    typedef struct packed {
        logic periphReq;
        logic [1:0] periphLevel;
        logic extReq;
        logic [1:0] extLevel;
        logic watchReq;
        logic [1:0] watchLevel;
    } smc_wake_t;

    // Clock and power gating outputs.
    typedef struct packed {
        logic cpuClkEn;
        logic periphClkEn;
        logic watchdogClkEn;
        logic timebaseClkEn;
        logic mainOscEn;
        logic subOscEn;
        logic watchPrescalerEn;
        logic watchIrqAllow;
        logic extIrqEn;
    } smc_gate_t;

endpackage : smc_pkg

// ===== logic/smc_soft_reset.sv
// Software reset pulse stretcher for the standby mode controller.
// Assumes the trigger is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps

module smc_soft_reset (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic trigger,
    input wire logic holdOn,
    // Result
    output logic softResetActive
);

    logic [smc_pkg::SRST_CNT_W-1:0] count_q;
    logic [smc_pkg::SRST_CNT_W-1:0] count_d;
    wire logic counting;
    localparam logic [smc_pkg::SRST_CNT_W-1:0] LOAD =
        smc_pkg::SRST_CNT_W'(smc_pkg::SOFT_RESET_CYCLES);

    assign counting = (count_q != '0);
    assign count_d = trigger ? LOAD :
        (counting ? count_q - 1'b1 : count_q);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_q <= '0;
            softResetActive <= 1'b0;
        end else begin
            count_q <= count_d;
            // Reset stays asserted through a pending oscillator wait.
            softResetActive <= trigger | (count_d != '0) | holdOn;
        end
    end

endmodule : smc_soft_reset

// ===== sim/smc_assertions.sv
// Port checker of the standby mode controller.
// Assumes it is bound into the controller and sees only its ports.
`timescale 1ns/1ps
module smc_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port and interrupts
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic irqPending,
    // Gating and status
    input wire smc_pkg::smc_gate_t gate,
    input wire logic pinHold,
    input wire logic pinFloat,
    input wire logic pinPullHigh,
    input wire logic internalReset,
    input wire logic wakeResume,
    input wire smc_pkg::smc_state_t modeState
);
    smc_pkg::smc_state_t prevState;
    logic prevWrite;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prevState <= smc_pkg::ST_RESET_WAIT;
            prevWrite <= 1'b0;
        end else begin
            prevState <= modeState;
            prevWrite <= regWrite;
        end
    end
    // Gating is judged once a state has held a cycle, as the gate
    // outputs may trail the state code by one edge.
    wire steady = modeState == prevState;
    wire ctlWr = regWrite && regAddr == smc_pkg::ADDR_STANDBY_CONTROL;
    wire inMain = steady && modeState == smc_pkg::ST_MAIN_RUN;
    wire parked = steady && (modeState == smc_pkg::ST_STOP ||
        modeState == smc_pkg::ST_WATCH);
    ////////////////////////////////////////
    sleep_gate_a:
        assert property (steady && modeState == smc_pkg::ST_SLEEP |->
            !gate.cpuClkEn && !gate.watchdogClkEn && gate.periphClkEn)
        else $error("sleep gating wrong");
    stop_gate_a:
        assert property (steady && modeState == smc_pkg::ST_STOP |->
            !gate.cpuClkEn && !gate.mainOscEn && !gate.periphClkEn &&
            !gate.watchIrqAllow && gate.extIrqEn)
        else $error("stop gating wrong");
    watch_gate_a:
        assert property (steady && modeState == smc_pkg::ST_WATCH |->
            !gate.cpuClkEn && !gate.mainOscEn && gate.watchPrescalerEn &&
            gate.watchIrqAllow && gate.extIrqEn)
        else $error("watch gating wrong");
    pin_state_a:
        assert property (parked |-> pinHold != (pinFloat || pinPullHigh))
        else $error("pin state wrong");
    refused_write_a:
        assert property (ctlWr && regWdata[4] && irqPending && inMain &&
            !prevWrite |=> ##1 modeState == smc_pkg::ST_MAIN_RUN)
        else $error("request taken while pending");
    soft_reset_a:
        assert property (ctlWr && !regWdata[4] && inMain |->
            ##[1:3] internalReset)
        else $error("software reset missing");
    resume_pulse_a:
        assert property (wakeResume |=> !wakeResume)
        else $error("resume pulse too long");
    reset_hold_a:
        assert property (modeState == smc_pkg::ST_RESET_WAIT |->
            internalReset)
        else $error("reset dropped during wait");
endmodule : smc_assertions

// ===== sim/smc_partner.sv
// Model of the interrupt sources and oscillator timers around the
// controller.
// Assumes the bench names the source and level of each wake request.
`timescale 1ns/1ps
module smc_partner (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Requests from the bench: periph, external, watch
    input wire logic [2:0] ask,
    input wire logic [1:0] level,
    input wire logic [3:0] slow,
    // Device side
    input wire smc_pkg::smc_state_t modeState,
    output smc_pkg::smc_wake_t wake,
    output logic timebaseReady,
    output logic watchPrescalerReady
);
    logic [3:0] waitCnt;
    wire waiting = modeState == smc_pkg::ST_OSC_WAIT ||
        modeState == smc_pkg::ST_RESET_WAIT;
    // Ready comes slow cycles into a wait, once; the count saturates so
    // a lagging state code cannot earn a second strobe.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wake <= '0;
            waitCnt <= 4'h0;
            timebaseReady <= 1'b0;
            watchPrescalerReady <= 1'b0;
        end else begin
            wake <= {ask[2], level, ask[1], level, ask[0], level};
            waitCnt <= !waiting ? 4'h0 : waitCnt + {3'h0, waitCnt != 4'hf};
            timebaseReady <= waiting && waitCnt == slow;
            watchPrescalerReady <= waiting && waitCnt == slow;
        end
    end
endmodule : smc_partner

// ===== sim/smc_tb.sv
// Self-checking bench of the standby mode controller.
// Assumes the partner model supplies wake requests and ready strobes.
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic systemClockSourceSelect = 1'b1;
    logic irqPending = 1'b0;
    logic pullUpSelect = 1'b0;
    logic [2:0] ask = 3'h0;
    logic [1:0] level = 2'h0;
    logic [3:0] slow = 4'h2;
    logic [7:0] regRdata, rdv;
    logic [7:0] req [3] = '{8'h90, 8'h50, 8'h18};
    logic timebaseReady, watchPrescalerReady, pinHold, pinFloat, pf;
    logic pinPullHigh, internalReset, wakeResume;
    smc_pkg::smc_wake_t wake;
    smc_pkg::smc_gate_t gate;
    smc_pkg::smc_state_t modeState;
    int err_total = 0;
    int tests_run = 0;
    int seed = 32'h85b6;
    int n, cyc;
    always #25 clk_sys = ~clk_sys;
    standby_mode_controller dut (.clk_sys, .reset, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .systemClockSourceSelect,
        .irqPending, .wake, .timebaseReady, .watchPrescalerReady,
        .pullUpSelect, .gate, .pinHold, .pinFloat, .pinPullHigh,
        .internalReset, .wakeResume, .modeState);
    smc_partner partner (.clk_sys, .reset, .ask, .level, .slow, .modeState,
        .wake, .timebaseReady, .watchPrescalerReady);
    ////////////////////////////////////////
    function automatic logic [7:0] pinExp(input logic f, input logic u);
        return {5'h0, ~f, f & ~u, f & u};
    endfunction : pinExp
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic chkSt(input smc_pkg::smc_state_t exp);
        @(negedge clk_sys);
        chk({5'h0, modeState}, {5'h0, exp});
        @(posedge clk_sys);
    endtask : chkSt
    // Every task that waits on the clock starts and ends just after a rising edge.
    task automatic wr(input logic [7:0] d);
        regAddr <= smc_pkg::ADDR_STANDBY_CONTROL;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        rdv = regRdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic wakeUp(input logic [2:0] src, input logic [1:0] lv,
            input smc_pkg::smc_state_t back);
        ask <= src;
        level <= lv;
        for (cyc = 0; cyc < 80 && wakeResume !== 1'b1; cyc++) begin
            @(negedge clk_sys);
        end
        chk({7'h0, wakeResume}, 8'h01);
        @(posedge clk_sys);
        ask <= 3'h0;
        // The state code trails the resume pulse by one edge.
        chkSt(back);
    endtask : wakeUp
    task automatic rstLen();
        for (cyc = 0; cyc < 8 && internalReset !== 1'b1; cyc++) begin
            @(negedge clk_sys);
        end
        for (cyc = 0; cyc < 200 && internalReset === 1'b1; cyc++) begin
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
    endtask : rstLen
    task automatic finish_test();
        $display("mismatches %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    initial begin
        #2000000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rstLen();
        rd(smc_pkg::ADDR_STANDBY_CONTROL);
        chk(rdv, {3'h0, 2'h2, smc_pkg::UNUSED_READ});
        wr(8'h37);
        rd(smc_pkg::ADDR_STANDBY_CONTROL);
        chk(rdv, {3'h1, 2'h2, smc_pkg::UNUSED_READ});
        rd(4'hf);
        chk(rdv & 8'hc8, 8'h00);
        irqPending <= 1'b1;
        for (n = 0; n < 3; n++) begin
            wr(req[n]);
            chkSt(smc_pkg::ST_MAIN_RUN);
        end
        rd(smc_pkg::ADDR_STANDBY_CONTROL);
        chk(rdv & 8'hc8, 8'h00);
        irqPending <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chkSt(smc_pkg::ST_MAIN_RUN);
        wr(8'h18);
        chkSt(smc_pkg::ST_MAIN_RUN);
        for (n = 0; n < 6; n++) begin
            pf = $random(seed);
            pullUpSelect <= $random(seed);
            // Timers are set afresh each pass, as after a real wake.
            slow <= 4'h1 + 4'({$random(seed)} % 9);
            wr({~n[0], n[0], pf, 2'h2, 3'($random(seed))});
            chkSt(n[0] ? smc_pkg::ST_SLEEP : smc_pkg::ST_STOP);
            if (!n[0]) begin
                chk({5'h0, pinHold, pinFloat, pinPullHigh},
                    pinExp(pf, pullUpSelect));
            end
            ask <= 3'h4;
            level <= n[0] ? 2'h3 : 2'({$random(seed)} % 3);
            repeat (6) @(posedge clk_sys);
            chkSt(n[0] ? smc_pkg::ST_SLEEP : smc_pkg::ST_STOP);
            wakeUp(n[0] ? 3'h4 : 3'h2, 2'({$random(seed)} % 3),
                smc_pkg::ST_MAIN_RUN);
            chk({7'h0, n[0] || cyc > slow + 4}, 8'h01);
        end
        wr(8'h00);
        rstLen();
        chk(8'(cyc), 8'(smc_pkg::SOFT_RESET_CYCLES));
        systemClockSourceSelect <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chkSt(smc_pkg::ST_SUB_RUN);
        wr(8'h58);
        chkSt(smc_pkg::ST_WATCH);
        rd(smc_pkg::ADDR_STATUS);
        chk(rdv, {5'h0, smc_pkg::ST_WATCH});
        wakeUp(3'h1, 2'h0, smc_pkg::ST_SUB_RUN);
        wr(8'hd8);
        chkSt(smc_pkg::ST_STOP);
        wakeUp(3'h2, 2'h1, smc_pkg::ST_SUB_RUN);
        irqPending <= 1'b1;
        wr(8'h18);
        chkSt(smc_pkg::ST_SUB_RUN);
        irqPending <= 1'b0;
        wr(8'h00);
        systemClockSourceSelect <= 1'b1;
        rstLen();
        chkSt(smc_pkg::ST_MAIN_RUN);
        finish_test();
    end
endmodule : testbench
bind standby_mode_controller smc_assertions portChk (.clk_sys, .reset,
    .regAddr, .regWdata, .regWrite, .irqPending, .gate, .pinHold,
    .pinFloat, .pinPullHigh, .internalReset, .wakeResume, .modeState);
